// file: src/ems_cycdiv.sv
// instruction cycle divider producing the clock output and cycle strobe
`timescale 1ns/1ps
module ems_cycdiv #(
  parameter int unsigned RATIO_SMALL = 4,
  parameter int unsigned RATIO_WIDE = 16
) (
  // clock and control
  input wire logic clk,
  input wire logic restart,
  input wire logic mode_small,
  // outputs, both from flip-flops
  output logic clk_out,
  output logic cycle_start
);

  localparam int unsigned CW = $clog2(RATIO_WIDE);

  initial begin
    if (RATIO_SMALL < 2 || RATIO_WIDE < RATIO_SMALL || RATIO_SMALL % 2 != 0 || RATIO_WIDE % 2 != 0) begin
      $error("divide ratios must be even, at least two, and ordered");
    end
  end

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic clk_out;
    logic start;
  } ems_div_state_t;

  ems_div_state_t s_q;
  ems_div_state_t s_d;
  logic [CW-1:0] last;
  logic [CW-1:0] half;

  // count through one instruction cycle; high for its first half
  always_comb begin
    last = mode_small ? CW'(RATIO_SMALL - 1) : CW'(RATIO_WIDE - 1);
    half = mode_small ? CW'(RATIO_SMALL / 2) : CW'(RATIO_WIDE / 2);
    s_d = s_q;
    // preload the last count so the first edge after a clear opens a full cycle
    if (restart) begin
      s_d.cnt = last;
    end else if (s_q.cnt >= last) begin
      s_d.cnt = '0;
    end else begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
    s_d.clk_out = (s_d.cnt < half) && !restart;
    s_d.start = (s_d.cnt == '0) && !restart;
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign clk_out = s_q.clk_out;
  assign cycle_start = s_q.start;

endmodule

// file: src/ems_pkg.sv
// shared constants and carrier types of the emulation mode select block
package ems_pkg;

  // instruction cycle divide ratios, in oscillator periods
  localparam int unsigned CYC_SMALL = 4;
  localparam int unsigned CYC_WIDE = 16;

  // return stack: levels per personality and word width
  localparam int unsigned STACK_DEPTH = 3;
  localparam int unsigned STACK_SMALL = 2;
  localparam int unsigned STACK_WIDE = 3;
  localparam int unsigned STACK_W = 9;

  // register byte offsets on the apb slave
  localparam logic [11:0] OFS_PORT1 = 12'h000;
  localparam logic [11:0] OFS_PORT2 = 12'h004;
  localparam logic [11:0] OFS_PORT3 = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00C;
  localparam logic [11:0] OFS_TICK = 12'h010;
  localparam logic [11:0] OFS_PUSH = 12'h014;
  localparam logic [11:0] OFS_POP = 12'h018;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h01C;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h020;
  localparam logic [11:0] OFS_MODE = 12'h024;

  // master clear values of the port file registers
  localparam logic [7:0] PORT_ONES = 8'hFF;
  localparam logic [7:0] PORT_ZEROS = 8'h00;

  // status file word: bits 3..7 fixed at one in the small personality
  localparam logic [7:0] STATUS_FIXED = 8'hF8;
  localparam logic [7:0] TICK_LAST = 8'hFF;

  // interrupt status and mask layout
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_TICK_WRAP = 0;
  localparam int unsigned IRQ_STK_OVF = 1;
  localparam int unsigned IRQ_STK_UNF = 2;

  // mode readback fields
  localparam int unsigned MODE_SMALL_BIT = 0;
  localparam int unsigned MODE_IRQ_EN_BIT = 1;

  // apb answer sequencing
  typedef enum logic {BUS_IDLE, BUS_ANSWER} ems_bus_t;

  // apb request as seen by the slave
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } ems_apb_req_t;

  // complete state of the top module
  typedef struct packed {
    logic mode_small;
    logic [7:0] port1;
    logic [7:0] port2;
    logic [7:0] port3;
    logic [7:0] status;
    logic [7:0] tick;
    logic tin_prev;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    ems_bus_t bus;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ems_top_state_t;

endpackage

// file: src/ems_stack.sv
// return stack with a run-time level limit and overflow/underflow flags
`timescale 1ns/1ps
module ems_stack #(
  parameter int unsigned DEPTH = 3,
  parameter int unsigned W = 9
) (
  // clock and control
  input wire logic clk,
  input wire logic clr,
  input wire logic push,
  input wire logic pop,
  input wire logic [$clog2(DEPTH+1)-1:0] limit,
  input wire logic [W-1:0] din,
  // state and events
  output logic [W-1:0] top,
  output logic [$clog2(DEPTH+1)-1:0] level,
  output logic ovf,
  output logic unf
);

  localparam int unsigned LW = $clog2(DEPTH + 1);

  initial begin
    if (DEPTH < 1 || W < 1) begin
      $error("stack needs at least one level of one bit");
    end
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [LW-1:0] level;
  } ems_stk_state_t;

  ems_stk_state_t s_q;
  ems_stk_state_t s_d;

  // a push beyond the limit is refused and flagged rather than wrapping
  always_comb begin
    s_d = s_q;
    ovf = push && (s_q.level >= limit);
    unf = pop && !push && (s_q.level == '0);
    if (clr) begin
      s_d.level = '0;
    end else if (push && !ovf) begin
      s_d.mem[s_q.level] = din;
      s_d.level = s_q.level + 1'b1;
    end else if (pop && !unf && !push) begin
      s_d.level = s_q.level - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign level = s_q.level;
  assign top = (s_q.level == '0) ? '0 : s_q.mem[s_q.level - 1'b1];

endmodule

// file: src/ems_top.sv
// mode-dependent personality logic of the emulation microcomputer
`timescale 1ns/1ps
module ems_top
  import ems_pkg::*;
#(
  parameter int unsigned DEPTH = STACK_DEPTH
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // application pins
  input wire logic MODE_SMALL,
  input wire logic MASTER_CLEAR_N,
  input wire logic TIMER_COUNT_INPUT,
  output logic CLK_OUT,
  output logic CYCLE_STROBE,
  output logic IRQ,
  output logic [7:0] FIRST_PORT_FILE,
  output logic [7:0] SECOND_PORT_FILE,
  output logic [7:0] THIRD_PORT_FILE,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);

  localparam int unsigned LW = $clog2(DEPTH + 1);

  initial begin
    if (DEPTH < STACK_WIDE) begin
      $error("stack depth must hold the interrupt-capable level count");
    end
  end

  ems_top_state_t s_q;
  ems_top_state_t s_d;
  ems_apb_req_t req;
  logic clear;
  logic commit;
  logic hit;
  logic [31:0] rd;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] w1c;
  logic tin_fall;
  logic stk_push;
  logic stk_pop;
  logic stk_ovf;
  logic stk_unf;
  logic [STACK_W-1:0] stk_top;
  logic [LW-1:0] stk_level;
  logic [LW-1:0] stk_limit;
  logic [7:0] status_view;
  logic div_clk_out;
  logic div_start;

  // gather the bus pins into one request
  assign req = '{sel: PSEL, enable: PENABLE, write: PWRITE, addr: PADDR, wdata: PWDATA};

  // either reset source reloads the personality and the port files
  assign clear = RST || !MASTER_CLEAR_N;

  // a write lands on the edge where the master sees pready high
  assign commit = (s_q.bus == BUS_ANSWER) && req.sel && req.enable;

  // small personality exposes only two return levels
  assign stk_limit = s_q.mode_small ? LW'(STACK_SMALL) : LW'(STACK_WIDE);

  // fixed ones overlay the upper status bits in the small personality
  assign status_view = s_q.mode_small ? (s_q.status | STATUS_FIXED) : s_q.status;

  // the oscillator pin is the only clock; the cycle divider runs off it
  ems_cycdiv #(
    .RATIO_SMALL(CYC_SMALL),
    .RATIO_WIDE(CYC_WIDE)
  ) u_div (
    .clk(REF_CLK),
    .restart(clear),
    .mode_small(s_q.mode_small),
    .clk_out(div_clk_out),
    .cycle_start(div_start)
  );

  ems_stack #(
    .DEPTH(DEPTH),
    .W(STACK_W)
  ) u_stack (
    .clk(REF_CLK),
    .clr(clear),
    .push(stk_push),
    .pop(stk_pop),
    .limit(stk_limit),
    .din(req.wdata[STACK_W-1:0]),
    .top(stk_top),
    .level(stk_level),
    .ovf(stk_ovf),
    .unf(stk_unf)
  );

  // read decode; unmapped addresses answer with an error
  always_comb begin
    rd = '0;
    hit = 1'b1;
    unique case (req.addr)
      OFS_PORT1: rd[7:0] = s_q.port1;
      OFS_PORT2: rd[7:0] = s_q.port2;
      OFS_PORT3: rd[7:0] = s_q.port3;
      OFS_STATUS: rd[7:0] = status_view;
      OFS_TICK: rd[7:0] = s_q.tick;
      OFS_PUSH: rd[STACK_W-1:0] = stk_top;
      OFS_POP: rd[LW-1:0] = stk_level;
      OFS_IRQ_STAT: rd[IRQ_W-1:0] = s_q.irq_stat;
      OFS_IRQ_MASK: rd[IRQ_W-1:0] = s_q.irq_mask;
      OFS_MODE: begin
        rd[MODE_SMALL_BIT] = s_q.mode_small;
        rd[MODE_IRQ_EN_BIT] = !s_q.mode_small;
      end
      default: hit = 1'b0;
    endcase
  end

  // stack commands fire once, at the committing edge
  assign stk_push = commit && req.write && (req.addr == OFS_PUSH);
  assign stk_pop = commit && req.write && (req.addr == OFS_POP);

  // timer input is sampled every oscillator edge, the same edge that moves
  // the clock output, so a tied-back clock output never slips a count
  assign tin_fall = s_q.tin_prev && !TIMER_COUNT_INPUT;

  always_comb begin
    w1c = '0;
    if (commit && req.write && req.addr == OFS_IRQ_STAT) begin
      w1c = req.wdata[IRQ_W-1:0];
    end
  end

  // event sources feeding the sticky status
  always_comb begin
    ev = '0;
    ev[IRQ_TICK_WRAP] = tin_fall && (s_q.tick == TICK_LAST);
    ev[IRQ_STK_OVF] = stk_ovf;
    ev[IRQ_STK_UNF] = stk_unf;
  end

  // next state of the whole block
  always_comb begin
    s_d = s_q;
    s_d.tin_prev = TIMER_COUNT_INPUT;

    // tick counter advances on trailing edges in both personalities
    if (tin_fall) begin
      s_d.tick = s_q.tick + 1'b1;
    end

    // bus answer: data is latched on the same edge that pready rises
    unique case (s_q.bus)
      BUS_IDLE: begin
        s_d.pready = 1'b0;
        if (req.sel && req.enable) begin
          s_d.bus = BUS_ANSWER;
          s_d.pready = 1'b1;
          s_d.pslverr = !hit;
          s_d.prdata = req.write ? '0 : rd;
        end
      end
      BUS_ANSWER: begin
        s_d.bus = BUS_IDLE;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        s_d.prdata = '0;
      end
    endcase

    // register writes
    if (commit && req.write) begin
      unique case (req.addr)
        OFS_PORT1: s_d.port1 = req.wdata[7:0];
        OFS_PORT2: s_d.port2 = req.wdata[7:0];
        OFS_PORT3: s_d.port3 = req.wdata[7:0];
        OFS_STATUS: s_d.status = req.wdata[7:0];
        OFS_TICK: s_d.tick = req.wdata[7:0];
        OFS_IRQ_MASK: s_d.irq_mask = req.wdata[IRQ_W-1:0];
        default: begin
        end
      endcase
    end

    // sticky events: a new event wins over a clear in the same cycle
    s_d.irq_stat = (s_q.irq_stat & ~w1c) | ev;

    // master clear or reset: catch the strap, then load the port files
    if (clear) begin
      s_d.mode_small = MODE_SMALL;
      s_d.status = '0;
      s_d.tick = '0;
      s_d.irq_stat = '0;
      s_d.irq_mask = '0;
      s_d.port1 = PORT_ONES;
      s_d.port2 = MODE_SMALL ? PORT_ONES : PORT_ZEROS;
      s_d.port3 = MODE_SMALL ? PORT_ONES : PORT_ZEROS;
    end

    // bus handshake state only follows the hard reset
    if (RST) begin
      s_d.bus = BUS_IDLE;
      s_d.pready = 1'b0;
      s_d.pslverr = 1'b0;
      s_d.prdata = '0;
      s_d.tin_prev = 1'b0;
    end

    // interrupt line is held off entirely in the small personality
    s_d.irq = !s_d.mode_small && |(s_d.irq_stat & s_d.irq_mask);
  end

  always_ff @(posedge REF_CLK) begin
    s_q <= s_d;
  end

  // outputs straight from flip-flops
  assign CLK_OUT = div_clk_out;
  assign CYCLE_STROBE = div_start;
  assign IRQ = s_q.irq;
  assign FIRST_PORT_FILE = s_q.port1;
  assign SECOND_PORT_FILE = s_q.port2;
  assign THIRD_PORT_FILE = s_q.port3;
  assign PRDATA = s_q.prdata;
  assign PREADY = s_q.pready;
  assign PSLVERR = s_q.pslverr;

endmodule

// file: verification/ems_app.sv
// model of the application circuit: master clear and timer input
`timescale 1ns/1ps
module ems_app (
  // clock and commands
  input wire logic clk,
  input wire logic hold_clr,
  input wire logic tie,
  input wire logic clk_out,
  // pins toward the block
  output logic master_clear_n,
  output logic timer_in
);
  logic [15:0] pwr_q = 16'h0000;
  logic mc_q = 1'b0;
  logic tin_q = 1'b1;
  // power-up count, 25001 cycles of 40 ns is over 1.0 ms
  always_ff @(posedge clk) begin
    if (pwr_q != 16'h61A9) begin
      pwr_q <= pwr_q + 16'h0001;
    end
    mc_q <= (pwr_q == 16'h61A9) && !hold_clr;
    tin_q <= tie ? clk_out : 1'b1;
  end
  // idle timer input rests high so no stray trailing edge
  assign master_clear_n = mc_q;
  assign timer_in = tin_q;
endmodule

// file: verification/ems_top_sva.sv
// port assertions of the mode select block
`timescale 1ns/1ps
module ems_top_sva
  import ems_pkg::*;
#(
  parameter int unsigned DEPTH = 3
) (
  // clock, reset, pins
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic MODE_SMALL,
  input wire logic MASTER_CLEAR_N,
  input wire logic CLK_OUT,
  input wire logic CYCLE_STROBE,
  input wire logic IRQ,
  input wire logic [7:0] FIRST_PORT_FILE,
  input wire logic [7:0] SECOND_PORT_FILE,
  input wire logic [7:0] THIRD_PORT_FILE,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // master clear restarts the divider, so it also aborts these
  cyc_small_a: assert property (disable iff (RST || !MASTER_CLEAR_N) CYCLE_STROBE && MODE_SMALL |->
    CLK_OUT[*2] ##1 !CLK_OUT[*2] ##1 CYCLE_STROBE) else $error("small cycle length wrong");
  cyc_wide_a: assert property (disable iff (RST || !MASTER_CLEAR_N) CYCLE_STROBE && !MODE_SMALL |->
    CLK_OUT[*8] ##1 !CLK_OUT[*8] ##1 CYCLE_STROBE) else $error("wide cycle length wrong");
  strobe_gap_a: assert property (CYCLE_STROBE |=> !CYCLE_STROBE[*3]) else $error("strobe too close");
  clr_small_a: assert property (!MASTER_CLEAR_N && MODE_SMALL |=> FIRST_PORT_FILE == PORT_ONES &&
    SECOND_PORT_FILE == PORT_ONES && THIRD_PORT_FILE == PORT_ONES) else $error("small clear ports");
  clr_wide_a: assert property (!MASTER_CLEAR_N && !MODE_SMALL |=> FIRST_PORT_FILE == PORT_ONES &&
    SECOND_PORT_FILE == PORT_ZEROS && THIRD_PORT_FILE == PORT_ZEROS) else $error("wide clear ports");
  irq_off_a: assert property (MODE_SMALL && MASTER_CLEAR_N |-> !IRQ) else $error("irq in small mode");
  ready_lat_a: assert property (PSEL && PENABLE && !$past(PENABLE) |=> PREADY ##1 !PREADY)
    else $error("apb answer timing");
  bad_addr_a: assert property (PSEL && PENABLE && !$past(PENABLE) && (PADDR > OFS_MODE || PADDR[1:0] != 2'h0)
    |=> PSLVERR && PRDATA == 32'h0000_0000) else $error("unmapped not refused");
  status_ones_a: assert property (PREADY && !PWRITE && PADDR == OFS_STATUS && MODE_SMALL |->
    PRDATA[7:3] == 5'h1F) else $error("status high bits not ones");
  mode_read_a: assert property (PREADY && !PWRITE && PADDR == OFS_MODE |->
    PRDATA == {30'h0, !MODE_SMALL, MODE_SMALL}) else $error("mode readback");
  cover property (PREADY && PSLVERR);
  cover property (IRQ);
  cover property (CYCLE_STROBE && !MODE_SMALL);
endmodule
bind ems_top ems_top_sva #(.DEPTH(DEPTH)) ems_top_sva_i (.REF_CLK(REF_CLK), .RST(RST),
  .MODE_SMALL(MODE_SMALL), .MASTER_CLEAR_N(MASTER_CLEAR_N), .CLK_OUT(CLK_OUT),
  .CYCLE_STROBE(CYCLE_STROBE), .IRQ(IRQ), .FIRST_PORT_FILE(FIRST_PORT_FILE),
  .SECOND_PORT_FILE(SECOND_PORT_FILE), .THIRD_PORT_FILE(THIRD_PORT_FILE), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR));

// file: verification/testbench.sv
// self-checking bench of the mode select block
`timescale 1ns/1ps
module testbench
  import ems_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic mode = 1'b1;
  logic hold = 1'b0;
  logic tie = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic master_clear_n_n, tin, clk_out, irq, pready, pslverr, err;
  logic [7:0] p1, p2, p3;
  int num_errors = 0;
  int comparisons = 0;

  ems_top #(.DEPTH(3)) ems_top_i (.REF_CLK(clk), .RST(rst), .MODE_SMALL(mode), .MASTER_CLEAR_N(master_clear_n_n),
    .TIMER_COUNT_INPUT(tin), .CLK_OUT(clk_out), .CYCLE_STROBE(), .IRQ(irq), .FIRST_PORT_FILE(p1),
    .SECOND_PORT_FILE(p2), .THIRD_PORT_FILE(p3), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
  ems_app ems_app_i (.clk(clk), .hold_clr(hold), .tie(tie), .clk_out(clk_out),
    .master_clear_n(master_clear_n_n), .timer_in(tin));

  initial begin
    forever #20 clk = ~clk;
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; entered right after a rising edge, pready sampled at rising edges
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // the request stands until the rising edge at which pready is seen high
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      num_errors++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  // overfill then overdrain the stack; irq only where enabled
  task automatic stack_test(input int lim, input logic irq_exp);
    for (int i = 1; i <= lim + 1; i++) begin
      apb(1'b1, OFS_PUSH, i);
    end
    rdchk(OFS_POP, lim);
    rdchk(OFS_PUSH, lim);
    apb(1'b1, OFS_IRQ_MASK, 32'h0000_0007);
    @(negedge clk);
    chk({31'h0, irq}, {31'h0, irq_exp});
    @(posedge clk);
    for (int i = 0; i <= lim; i++) begin
      apb(1'b1, OFS_POP, 32'h0000_0000);
    end
    rdchk(OFS_POP, 32'h0000_0000);
    rdchk(OFS_IRQ_STAT, 32'h0000_0006);
    apb(1'b1, OFS_IRQ_STAT, 32'h0000_0006);
    rdchk(OFS_IRQ_STAT, 32'h0000_0000);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0000_0000);
    @(posedge clk);
    apb(1'b1, OFS_IRQ_MASK, 32'h0000_0000);
    $display("stack test done, limit %0d", lim);
  endtask

  // clock output tied to the timer input: every trailing edge counts
  task automatic tick_test();
    int falls;
    logic prev;
    falls = 0;
    prev = 1'b1;
    apb(1'b1, OFS_TICK, 32'h0000_0000);
    tie <= 1'b1;
    for (int i = 0; i < 80; i++) begin
      @(negedge clk);
      falls += (prev && !tin) ? 1 : 0;
      prev = tin;
      if (i == 70) begin
        tie <= 1'b0;
      end
    end
    @(posedge clk);
    rdchk(OFS_TICK, falls);
    $display("tick test done, %0d edges", falls);
  endtask

  initial begin
    int n;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    n = 0;
    while (master_clear_n_n !== 1'b1 && n < 30000) begin
      @(negedge clk);
      n++;
    end
    if (master_clear_n_n !== 1'b1) begin
      num_errors++;
      finish_test();
    end
    @(posedge clk);
    // small personality, strap high since power-up
    chk({8'h00, p1, p2, p3}, 32'h00FF_FFFF);
    rdchk(OFS_MODE, 32'h0000_0001);
    apb(1'b1, OFS_STATUS, 32'h0000_0000);
    rdchk(OFS_STATUS, 32'h0000_00F8);
    stack_test(2, 1'b0);
    tick_test();
    $display("small personality test done");
    // switch the strap only once master clear is already low
    hold <= 1'b1;
    repeat (2) @(posedge clk);
    mode <= 1'b0;
    repeat (4) @(posedge clk);
    hold <= 1'b0;
    repeat (3) @(posedge clk);
    chk({8'h00, p1, p2, p3}, 32'h00FF_0000);
    rdchk(OFS_MODE, 32'h0000_0002);
    apb(1'b1, OFS_STATUS, 32'h0000_0000);
    rdchk(OFS_STATUS, 32'h0000_0000);
    stack_test(3, 1'b1);
    tick_test();
    apb(1'b0, 12'h028, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    $display("wide personality test done");
    finish_test();
  end
endmodule
